/* File: hdl/addr_range_match.sv */
`timescale 1ns/1ps

// Flags an address that lies inside an inclusive window.
module addr_range_match #(
  parameter int W = 32,
  parameter logic [W-1:0] LO = '0,
  parameter logic [W-1:0] HI = '1
)
(
  // Address under test.
  input wire logic [W-1:0] addr,
  // Window hit.
  output logic hit
);

  // Both bounds are inclusive.
  assign hit = (addr >= LO) && (addr <= HI);

endmodule

/* File: hdl/byte_lane_encode.sv */
`timescale 1ns/1ps

// Turns the eight byte enables into the three lowest address bits.
module byte_lane_encode
(
  // Active byte lanes, one per byte of the 64-bit data bus.
  input wire logic [7:0] byte_enable_lines,
  // Offset of the lowest enabled lane.
  output logic [2:0] low_addr,
  // No lane enabled.
  output logic no_lane
);

  // The lowest enabled lane gives the byte address inside the quad word.
  always_comb
  begin
    low_addr = 3'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (byte_enable_lines[i])
      begin
        low_addr = 3'(i);
      end
    end
    no_lane = (byte_enable_lines == 8'h00);
  end

endmodule

/* File: hdl/isa_decode_pkg.sv */
package isa_decode_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int CPU_AW = 32;
  localparam int ISA_AW = 24;
  localparam int IO_AW = 16;
  localparam int LANES = 8;

  // ****************************************************************
  // Processor memory map
  // ****************************************************************
  localparam logic [31:0] MAIN_LO_BEG = 32'h0000_0000;
  localparam logic [31:0] MAIN_LO_END = 32'h0009_FFFF;
  localparam logic [31:0] MAIN_HI_BEG = 32'h0010_0000;
  localparam logic [31:0] MAIN_HI_END = 32'h07FF_FFFF;
  localparam logic [31:0] LEGACY_BEG = 32'h000A_0000;
  localparam logic [31:0] LEGACY_END = 32'h000F_FFFF;
  localparam logic [31:0] HOLE_BEG = 32'h00F0_0000;
  localparam logic [31:0] HOLE_END = 32'h00FF_FFFF;
  localparam logic [23:0] DP_ISA_BEG = 24'hF8_0000;
  localparam logic [23:0] DP_ISA_END = 24'hFD_FFFF;
  localparam logic [7:0] DP_HIGH_BYTE = 8'hFF;
  localparam logic [3:0] LOW_MEG_TOP = 4'h0;

  // ****************************************************************
  // I/O map
  // ****************************************************************
  localparam logic [15:0] IO_CFG_PORT = 16'h0063;
  localparam logic [15:0] IO_CGA_BEG = 16'h03D0;
  localparam logic [15:0] IO_CGA_END = 16'h03DF;
  localparam logic [15:0] IO_MONO_BEG = 16'h03B0;
  localparam logic [15:0] IO_MONO_END = 16'h03BB;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [23:0] ISA_ADDR_RST = 24'h00_0000;

  // Destination of a processor cycle.
  typedef enum logic [1:0] {
    ROUTE_NONE,
    ROUTE_MAIN,
    ROUTE_PCI,
    ROUTE_ISA
  } route_t;

endpackage

/* File: hdl/isa_memory_io_address_decoder.sv */
`timescale 1ns/1ps

// Summary of operation
// R1 - Low 640 KiB and 1 MiB to 128 MiB never go to PCI.
// R2 - Main memory cycles raise no ISA strobes.
// R3 - ISA space appears exactly once inside the processor map; with the option on, ISA offsets F80000 to FDFFFF are reached twice.
// R4 - Twenty ISA address lines reach the lowest megabyte.
// R5 - Four upper lines extend ISA reach to sixteen megabytes.
// R6 - Low-megabyte strobes only when the four upper lines are zero.
// R7 - An ISA master cannot reach above sixteen megabytes.
// R8 - Dual-port window near the top maps to the same ISA offset.
// R9 - Processor bits 24 to 31 qualify the dual-port window.
// R10 - Option routes the sixteenth megabyte to ISA.
// R11 - Memory and I/O cycles use separate strobes.
// R12 - Processor gives A3 to A31 plus eight byte enables.
// R13 - Write to the one-byte configuration port selects it; reads do not.
// R14 - Colour block of sixteen bytes, monochrome block of twelve bytes.
// R15 - With the option off the sixteenth megabyte is main memory.
module isa_memory_io_address_decoder
(
  // Clock, reset and clock enable.
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Processor cycle, valid for one clock per cycle.
  input wire logic cyc_valid,
  input wire logic cyc_is_mem,
  input wire logic cyc_write,
  input wire logic [31:3] cpu_addr,
  input wire logic [7:0] byte_enable_lines,
  // Setup option for the sixteenth-megabyte ISA window.
  input wire logic isa_window_en,
  // ISA master request.
  input wire logic master_valid,
  input wire logic [23:0] master_addr,
  // Routing of the processor cycle.
  output logic main_sel,
  output logic pci_sel,
  // ISA address and strobes.
  output logic [23:0] isa_addr,
  output logic memory_read_strobe,
  output logic memory_write_strobe,
  output logic low_mem_read_strobe,
  output logic low_mem_write_strobe,
  output logic io_read_strobe,
  output logic io_write_strobe,
  // On-board I/O selects.
  output logic cfg_port_write,
  output logic cga_select,
  output logic mono_select,
  // ISA master routed to main memory.
  output logic master_main_sel
);

  // ****************************************************************
  // Address assembly
  // ****************************************************************

  logic [2:0] low_addr;
  logic no_lane;
  logic [31:0] full_addr;
  logic [15:0] io_addr;

  // Recover A0 to A2 from the byte enables.
  byte_lane_encode u_lanes
  (
    .byte_enable_lines(byte_enable_lines),
    .low_addr(low_addr),
    .no_lane(no_lane)
  );

  // The full byte address of the cycle.
  assign full_addr = {cpu_addr, low_addr}; // R12
  assign io_addr = full_addr[15:0];

  // ****************************************************************
  // Memory windows
  // ****************************************************************

  logic hit_main_lo;
  logic hit_main_hi;
  logic hit_legacy;
  logic hit_hole;
  logic hit_dp_low;
  logic dp_high_ok;

  addr_range_match #(
    .W(32),
    .LO(isa_decode_pkg::MAIN_LO_BEG),
    .HI(isa_decode_pkg::MAIN_LO_END)
  ) u_main_lo
  (
    .addr(full_addr),
    .hit(hit_main_lo)
  );

  addr_range_match #(
    .W(32),
    .LO(isa_decode_pkg::MAIN_HI_BEG),
    .HI(isa_decode_pkg::MAIN_HI_END)
  ) u_main_hi
  (
    .addr(full_addr),
    .hit(hit_main_hi)
  );

  addr_range_match #(
    .W(32),
    .LO(isa_decode_pkg::LEGACY_BEG),
    .HI(isa_decode_pkg::LEGACY_END)
  ) u_legacy
  (
    .addr(full_addr),
    .hit(hit_legacy)
  );

  addr_range_match #(
    .W(32),
    .LO(isa_decode_pkg::HOLE_BEG),
    .HI(isa_decode_pkg::HOLE_END)
  ) u_hole
  (
    .addr(full_addr),
    .hit(hit_hole)
  );

  addr_range_match #(
    .W(24),
    .LO(isa_decode_pkg::DP_ISA_BEG),
    .HI(isa_decode_pkg::DP_ISA_END)
  ) u_dp
  (
    .addr(full_addr[23:0]),
    .hit(hit_dp_low)
  );

  // Bits the ISA bus lacks decide whether the window is the high copy.
  assign dp_high_ok = (cpu_addr[31:24] == isa_decode_pkg::DP_HIGH_BYTE); // R9

  // ****************************************************************
  // I/O windows
  // ****************************************************************

  logic hit_cga;
  logic hit_mono;

  addr_range_match #(
    .W(16),
    .LO(isa_decode_pkg::IO_CGA_BEG),
    .HI(isa_decode_pkg::IO_CGA_END)
  ) u_cga
  (
    .addr(io_addr),
    .hit(hit_cga)
  );

  addr_range_match #(
    .W(16),
    .LO(isa_decode_pkg::IO_MONO_BEG),
    .HI(isa_decode_pkg::IO_MONO_END)
  ) u_mono
  (
    .addr(io_addr),
    .hit(hit_mono)
  );

  // ****************************************************************
  // Route decision
  // ****************************************************************

  isa_decode_pkg::route_t route;
  logic hole_to_isa;

  assign hole_to_isa = hit_hole && isa_window_en; // R10

  // I/O cycles to ISA first, then main memory, then each ISA window once, and PCI for the rest.
  always_comb
  begin
    if (!cyc_is_mem)
    begin
      route = isa_decode_pkg::ROUTE_ISA;
    end
    else if (hit_main_lo || (hit_main_hi && !hole_to_isa)) // R1 R15
    begin
      route = isa_decode_pkg::ROUTE_MAIN;
    end
    else if (hit_legacy || hole_to_isa || (hit_dp_low && dp_high_ok)) // R3 R8
    begin
      route = isa_decode_pkg::ROUTE_ISA;
    end
    else
    begin
      route = isa_decode_pkg::ROUTE_PCI;
    end
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************

  logic main_sel_ff, nxt_main_sel;
  logic pci_sel_ff, nxt_pci_sel;
  logic [23:0] isa_addr_ff, nxt_isa_addr;
  logic mem_rd_ff, nxt_mem_rd;
  logic mem_wr_ff, nxt_mem_wr;
  logic low_rd_ff, nxt_low_rd;
  logic low_wr_ff, nxt_low_wr;
  logic io_rd_ff, nxt_io_rd;
  logic io_wr_ff, nxt_io_wr;
  logic cfg_wr_ff, nxt_cfg_wr;
  logic cga_ff, nxt_cga;
  logic mono_ff, nxt_mono;
  logic master_ff, nxt_master;
  logic go;
  logic isa_mem;
  logic low_meg;

  assign go = cyc_valid && !no_lane;
  assign isa_mem = cyc_is_mem && (route == isa_decode_pkg::ROUTE_ISA);
  // Low-megabyte strobes need A20 to A23 all low.
  assign low_meg = (full_addr[23:20] == isa_decode_pkg::LOW_MEG_TOP); // R6

  // Strobes and selects are one-clock pulses; the address is held.
  always_comb
  begin
    nxt_main_sel = go && (route == isa_decode_pkg::ROUTE_MAIN);
    nxt_pci_sel = go && (route == isa_decode_pkg::ROUTE_PCI); // R1
    nxt_isa_addr = isa_addr_ff;
    if (go && route == isa_decode_pkg::ROUTE_ISA)
    begin
      // Twenty lines plus the four upper ones carry the offset.
      nxt_isa_addr = full_addr[23:0]; // R4 R5 R8
    end
    // Memory strobes only for ISA-routed memory cycles.
    nxt_mem_rd = go && isa_mem && !cyc_write; // R2 R11
    nxt_mem_wr = go && isa_mem && cyc_write; // R2 R11
    nxt_low_rd = go && isa_mem && low_meg && !cyc_write; // R6
    nxt_low_wr = go && isa_mem && low_meg && cyc_write; // R6
    // I/O cycles have their own pair of strobes.
    nxt_io_rd = go && !cyc_is_mem && !cyc_write; // R11
    nxt_io_wr = go && !cyc_is_mem && cyc_write; // R11
    // The configuration port is write only.
    nxt_cfg_wr = go && !cyc_is_mem && cyc_write &&
                 (io_addr == isa_decode_pkg::IO_CFG_PORT); // R13
    nxt_cga = go && !cyc_is_mem && hit_cga; // R14
    nxt_mono = go && !cyc_is_mem && hit_mono; // R14
    // A 24-bit master address can only land below sixteen megabytes.
    nxt_master = master_valid &&
                 ({8'h00, master_addr} <= isa_decode_pkg::MAIN_HI_END) &&
                 !({8'h00, master_addr} >= isa_decode_pkg::LEGACY_BEG &&
                   {8'h00, master_addr} <= isa_decode_pkg::LEGACY_END) &&
                 !({8'h00, master_addr} >= isa_decode_pkg::HOLE_BEG &&
                   isa_window_en); // R7
  end

  // Registers frozen while the clock enable is low.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      main_sel_ff <= 1'b0;
      pci_sel_ff <= 1'b0;
      isa_addr_ff <= isa_decode_pkg::ISA_ADDR_RST;
      mem_rd_ff <= 1'b0;
      mem_wr_ff <= 1'b0;
      low_rd_ff <= 1'b0;
      low_wr_ff <= 1'b0;
      io_rd_ff <= 1'b0;
      io_wr_ff <= 1'b0;
      cfg_wr_ff <= 1'b0;
      cga_ff <= 1'b0;
      mono_ff <= 1'b0;
      master_ff <= 1'b0;
    end
    else if (ce)
    begin
      main_sel_ff <= nxt_main_sel;
      pci_sel_ff <= nxt_pci_sel;
      isa_addr_ff <= nxt_isa_addr;
      mem_rd_ff <= nxt_mem_rd;
      mem_wr_ff <= nxt_mem_wr;
      low_rd_ff <= nxt_low_rd;
      low_wr_ff <= nxt_low_wr;
      io_rd_ff <= nxt_io_rd;
      io_wr_ff <= nxt_io_wr;
      cfg_wr_ff <= nxt_cfg_wr;
      cga_ff <= nxt_cga;
      mono_ff <= nxt_mono;
      master_ff <= nxt_master;
    end
  end

  assign main_sel = main_sel_ff;
  assign pci_sel = pci_sel_ff;
  assign isa_addr = isa_addr_ff;
  assign memory_read_strobe = mem_rd_ff;
  assign memory_write_strobe = mem_wr_ff;
  assign low_mem_read_strobe = low_rd_ff;
  assign low_mem_write_strobe = low_wr_ff;
  assign io_read_strobe = io_rd_ff;
  assign io_write_strobe = io_wr_ff;
  assign cfg_port_write = cfg_wr_ff;
  assign cga_select = cga_ff;
  assign mono_select = mono_ff;
  assign master_main_sel = master_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************

  sequence mem_req;
    ce && go && cyc_is_mem;
  endsequence

  sequence io_req;
    ce && go && !cyc_is_mem;
  endsequence

  a_main_no_strobe: assert property (@(posedge sys_clk) disable iff (rst) // R2
    mem_req ##0 (hit_main_lo || (hit_main_hi && !hole_to_isa)) |=>
      main_sel && !memory_read_strobe && !memory_write_strobe)
    else $error("Main memory cycle raised an ISA strobe.");

  a_pci_excluded: assert property (@(posedge sys_clk) disable iff (rst) // R1
    mem_req ##0 (full_addr <= isa_decode_pkg::MAIN_LO_END) |=> !pci_sel)
    else $error("Low main memory cycle went to PCI.");

  a_dual_port_map: assert property (@(posedge sys_clk) disable iff (rst) // R8
    mem_req ##0 (hit_dp_low && dp_high_ok) |=>
      memory_read_strobe || memory_write_strobe ##0
      isa_addr == $past(full_addr[23:0]))
    else $error("Dual-port window not mapped to its ISA offset.");

  a_dp_high_qual: assert property (@(posedge sys_clk) disable iff (rst) // R9
    mem_req ##0 (full_addr[31:24] == 8'hFE) ##0 hit_dp_low |=>
      pci_sel)
    else $error("Dual-port window taken without upper byte match.");

  a_low_meg_gate: assert property (@(posedge sys_clk) disable iff (rst) // R6
    (low_mem_read_strobe || low_mem_write_strobe) |->
      isa_addr[23:20] == 4'h0 && (memory_read_strobe || memory_write_strobe))
    else $error("Low-megabyte strobe with upper address lines set.");

  a_io_mem_split: assert property (@(posedge sys_clk) disable iff (rst) // R11
    io_req |=> (io_read_strobe || io_write_strobe) &&
      !memory_read_strobe && !memory_write_strobe)
    else $error("I/O cycle produced a memory strobe.");

  a_cfg_port: assert property (@(posedge sys_clk) disable iff (rst) // R13
    cfg_port_write |-> io_write_strobe && !io_read_strobe &&
      isa_addr[15:0] == 16'h0063)
    else $error("Configuration port selected on a wrong cycle.");

  a_video_block: assert property (@(posedge sys_clk) disable iff (rst) // R14
    (cga_select |-> isa_addr[15:4] == 12'h03D) and
    (mono_select |-> isa_addr[15:4] == 12'h03B && isa_addr[3:0] <= 4'hB))
    else $error("Video select outside its block.");

  a_window_option: assert property (@(posedge sys_clk) disable iff (rst) // R15
    mem_req ##0 hit_hole ##0 !isa_window_en |=>
      main_sel && !memory_read_strobe && !memory_write_strobe)
    else $error("Disabled window still reached the ISA bus.");

endmodule

/* File: verif/cpu_bus_model.sv */
`timescale 1ns/1ps

// ****************************************************************
// Processor bus master
// ****************************************************************

// Turns a byte address request into one processor bus cycle.
module cpu_bus_model
(
  // Clock.
  input wire logic sys_clk,
  // Request from the bench.
  input wire logic req,
  input wire logic req_mem,
  input wire logic req_write,
  input wire logic [31:0] req_addr,
  // Processor bus.
  output logic cyc_valid,
  output logic cyc_is_mem,
  output logic cyc_write,
  output logic [31:3] cpu_addr,
  output logic [7:0] byte_enable_lines
);
  // Start from a quiet bus.
  initial
  begin
    cyc_valid = 1'b0;
    cyc_is_mem = 1'b0;
    cyc_write = 1'b0;
    cpu_addr = 29'h0;
    byte_enable_lines = 8'h00;
  end

  // Idle address lines toggle, so a stale address never looks valid.
  always @(posedge sys_clk)
  begin
    cyc_valid <= req;
    cyc_is_mem <= req_mem;
    cyc_write <= req_write;
    if (req)
    begin
      cpu_addr <= req_addr[31:3];
      byte_enable_lines <= 8'h01 << req_addr[2:0];
    end
    else
    begin
      cpu_addr <= ~cpu_addr;
      byte_enable_lines <= 8'h00;
    end
  end
endmodule

/* File: verif/isa_memory_io_address_decoder_tb.sv */
`timescale 1ns/1ps

`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module isa_memory_io_address_decoder_tb;
  logic sys_clk, rst, ce, isa_window_en, master_valid;
  logic req, req_mem, req_write;
  logic [31:0] req_addr, r, a;
  logic [23:0] master_addr;
  logic cyc_valid, cyc_is_mem, cyc_write, main_sel, pci_sel;
  logic [31:3] cpu_addr;
  logic [7:0] byte_enable_lines;
  logic [23:0] isa_addr;
  logic mrd, mwr, lrd, lwr, iord, iowr, cfg, cga, mono, mmain;
  logic [10:0] outs;
  integer seed, n_fail, checks_done, cycles;
  logic [31:0] mem_pts [15] = '{32'h0, 32'h9FFF8, 32'hA0000, 32'hFFFF8,
    32'h100000, 32'hEFFFF8, 32'hF00000, 32'hFFFFF8, 32'h7FFFFF8,
    32'h8000000, 32'hFFF7FFF8, 32'hFFF80000, 32'hFFFDFFF8, 32'hFFFE0000,
    32'hFEF80000};
  logic [31:0] io_pts [9] = '{32'h63, 32'h62, 32'h3D0, 32'h3DF, 32'h3E0,
    32'h3B0, 32'h3BB, 32'h3BC, 32'h3AF};

  assign outs = {main_sel, pci_sel, mrd, mwr, lrd, lwr, iord, iowr, cfg,
    cga, mono};

  // Clock of 100 MHz.
  always #5 sys_clk = ~sys_clk;

  cpu_bus_model i_cpu (.sys_clk(sys_clk), .req(req), .req_mem(req_mem),
    .req_write(req_write), .req_addr(req_addr), .cyc_valid(cyc_valid),
    .cyc_is_mem(cyc_is_mem), .cyc_write(cyc_write), .cpu_addr(cpu_addr),
    .byte_enable_lines(byte_enable_lines));

  isa_memory_io_address_decoder i_dut (.sys_clk(sys_clk), .rst(rst),
    .ce(ce), .cyc_valid(cyc_valid), .cyc_is_mem(cyc_is_mem),
    .cyc_write(cyc_write), .cpu_addr(cpu_addr),
    .byte_enable_lines(byte_enable_lines), .isa_window_en(isa_window_en),
    .master_valid(master_valid), .master_addr(master_addr),
    .main_sel(main_sel), .pci_sel(pci_sel), .isa_addr(isa_addr),
    .memory_read_strobe(mrd), .memory_write_strobe(mwr),
    .low_mem_read_strobe(lrd), .low_mem_write_strobe(lwr),
    .io_read_strobe(iord), .io_write_strobe(iowr), .cfg_port_write(cfg),
    .cga_select(cga), .mono_select(mono), .master_main_sel(mmain));

  // ****************************************************************
  // Expected results
  // ****************************************************************

  // Selects and strobes expected for one processor cycle.
  function automatic logic [10:0] exp_cpu(logic [31:0] x, logic m,
    logic w, logic en);
    logic hole, main, isa;
    logic [10:0] e;
    e = 11'h0;
    hole = en && x >= 32'hF00000 && x <= 32'hFFFFFF;
    main = x <= 32'h9FFFF || (x >= 32'h100000 && x <= 32'h7FFFFFF && !hole);
    isa = !main && ((x >= 32'hA0000 && x <= 32'hFFFFF) || hole ||
      (x >= 32'hFFF80000 && x <= 32'hFFFDFFFF));
    if (!m)
    begin
      e[4] = !w;
      e[3] = w;
      e[2] = w && x[15:0] == 16'h0063;
      e[1] = x[15:0] >= 16'h03D0 && x[15:0] <= 16'h03DF;
      e[0] = x[15:0] >= 16'h03B0 && x[15:0] <= 16'h03BB;
    end
    else
    begin
      e[10] = main;
      e[9] = !main && !isa;
      e[8] = isa && !w;
      e[7] = isa && w;
      e[6] = isa && !w && x[23:20] == 4'h0;
      e[5] = isa && w && x[23:20] == 4'h0;
    end
    return e;
  endfunction

  // Whether an ISA master address lands in main memory.
  function automatic logic exp_master(logic [23:0] x, logic en);
    return x <= 24'h9FFFF || (x >= 24'h100000 && !(en && x >= 24'hF00000));
  endfunction

  // ****************************************************************
  // Bus tasks
  // ****************************************************************

  // One processor cycle, answer one clock after the taking edge.
  task automatic cpu_op(logic [31:0] x, logic m, logic w, logic en);
    logic [10:0] e;
    @(posedge sys_clk);
    req <= 1'b1;
    req_addr <= x;
    req_mem <= m;
    req_write <= w;
    isa_window_en <= en;
    @(posedge sys_clk);
    req <= 1'b0;
    @(posedge sys_clk);
    #1;
    e = exp_cpu(x, m, w, en);
    `CHK(outs, e);
    if (!m || e[8] || e[7])
      `CHK(isa_addr, x[23:0]);
    @(posedge sys_clk);
    #1;
    `CHK(outs, 11'h0);
  endtask

  // One ISA master request.
  task automatic master_op(logic [23:0] x, logic en);
    @(posedge sys_clk);
    master_valid <= 1'b1;
    master_addr <= x;
    isa_window_en <= en;
    @(posedge sys_clk);
    master_valid <= 1'b0;
    #1;
    `CHK(mmain, exp_master(x, en));
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Cuts a hung run short.
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      wrap_up();
    end
  end

  // Corner cases on the window boundaries (not 0x64, 0x3CF or 0x1000000), then random traffic.
  initial
  begin
    sys_clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    req = 1'b0;
    req_mem = 1'b0;
    req_write = 1'b0;
    req_addr = 32'h0;
    isa_window_en = 1'b0;
    master_valid = 1'b0;
    master_addr = 24'h0;
    seed = 32'h99ED;
    n_fail = 0;
    checks_done = 0;
    cycles = 0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    #1;
    `CHK({outs, isa_addr, mmain}, 36'h0);
    for (int en = 0; en < 2; en++)
    begin
      foreach (mem_pts[i])
      begin
        cpu_op(mem_pts[i], 1'b1, 1'b0, en[0]);
        cpu_op(mem_pts[i], 1'b1, 1'b1, en[0]);
        master_op(mem_pts[i][23:0], en[0]);
      end
    end
    foreach (io_pts[i])
    begin
      cpu_op(io_pts[i], 1'b0, 1'b0, 1'b0);
      cpu_op(io_pts[i], 1'b0, 1'b1, 1'b0);
    end
    repeat (80)
    begin
      r = $random(seed);
      a = $random(seed);
      if (!r[1])
        a = a & 32'hFFFF;
      else if (r[3])
        a = a & 32'hFFFFFF;
      cpu_op(a, r[1], r[2], r[0]);
      master_op(a[23:0], r[0]);
    end
    wrap_up();
  end
endmodule
